// File: fault_flags_params.svh
// constants for the fault flag aggregator
`ifndef FAULT_FLAGS_PARAMS_SVH
`define FAULT_FLAGS_PARAMS_SVH

// field threshold reset codes (steps of 32 g and 16 g)
`define FIELD_HI_RESET 6'h25
`define FIELD_LO_RESET 6'h0d
`define FIELD_THR_OFF 6'h00

// fault word bit positions
`define FLT_SUPPLY_LOW 0
`define FLT_FIELD_LOW 1
`define FLT_OSC 2
`define FLT_NVM_UNCORR 3
`define FLT_ZERO_CROSS 4
`define FLT_PLL 5
`define FLT_POWER_LOSS 6
`define FLT_ENC_SKIP 7
`define FLT_REG_DRIFT 8
`define FLT_AVG_SPAN 9

// caution word bit positions
`define CAU_FIELD_HIGH 0
`define CAU_TEMP 1
`define CAU_NVM_CORR 2
`define CAU_TURNS_SAT 3
`define CAU_TURNS_SPEED 4
`define CAU_FRAME 5
`define CAU_CRC 6

// turns and angle limits
`define TURNS_LIMIT 9'h100
`define ANGLE_JUMP_LIMIT 12'h600
`define QUAD_SPAN_LIMIT 3'h2

`endif

// File: fault_flags_pkg.sv
// types for the fault flag aggregator
package fault_flags_pkg;

	typedef struct packed {
		logic supply_low;
		logic field_low_n;
		logic osc_mismatch;
		logic nvm_single;
		logic nvm_multi;
		logic zero_cross_diff;
		logic pll_unlocked;
		logic temp_out;
		logic enc_step;
		logic [1:0] enc_state;
		logic reg_drift;
		logic turn_step;
		logic turn_up;
		logic [11:0] angle;
		logic avg_end;
		logic frame_end;
		logic frame_bad;
		logic frame_crc_bad;
		logic frame_is_20bit;
	} monitor_in_type;

	typedef struct packed {
		logic [9:0] fault_word;
		logic [6:0] caution_word;
		logic undervoltage_summary;
		logic general_error_flag;
	} flag_out_type;

endpackage

// File: fault_flag_aggregator.sv
// fault and caution flag collection for the angle sensor
//
// Overview of operation
// - supply below threshold sets supply-low, undervoltage summary and general error
// - field above programmable high limit sets field-high caution flag
// - field below programmable low limit sets field-low fault flag
// - temperature out of range sets temp-range flag and general error
// - oscillator cross-check discrepancy sets oscillator mismatch fault flag
// - corrected single-bit memory error sets corrected-error caution flag
// - uncorrectable memory error sets uncorrectable flag and general error
// - main path disagreeing with zero-crossing path sets mismatch fault flag
// - pll lock loss sets pll-unlocked fault flag
// - power loss then restore sets power-loss fault flag
// - skipped encoder output state sets encoder skip fault flag
// - regulator drift sets drift flag, undervoltage summary and general error
// - turns counter saturating past 256 rotations sets turns-saturated flag
// - over 135 degrees between turns updates sets turns-speed flag
// - samples reaching 2 quadrants from the first sample's quadrant in averaging period set span flag
// - bad clock count or set top bit in frame sets frame-format flag
// - checksum mismatch on 20-bit frames with checking on sets checksum flag
// - any unmasked flag asserts general error flag
// - all flags readable by the host on the flags output port
`timescale 1ns/1ps
`default_nettype none
`include "fault_flags_params.svh"

module fault_flag_aggregator #(
	parameter int FAULT_W = 10,
	parameter int CAUTION_W = 7
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// monitor inputs
	input wire fault_flags_pkg::monitor_in_type mon,
	input wire logic [5:0] field_level_hi,
	input wire logic [5:0] field_level_lo,
	// configuration
	input wire logic [5:0] field_high_limit,
	input wire logic [5:0] field_low_limit,
	input wire logic crc_check_enable,
	input wire logic [FAULT_W-1:0] fault_mask,
	input wire logic [CAUTION_W-1:0] caution_mask,
	// host clear strobes
	input wire logic [FAULT_W-1:0] fault_clear,
	input wire logic [CAUTION_W-1:0] caution_clear,
	// flags
	output var fault_flags_pkg::flag_out_type flags
);
	import fault_flags_pkg::*;

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [FAULT_W-1:0] fault;
		logic [CAUTION_W-1:0] caution;
		logic [1:0] enc_prev;
		logic enc_valid;
		logic [8:0] turns;
		logic [11:0] turn_angle;
		logic [1:0] quad_first;
		logic [2:0] quad_span;
		logic span_valid;
		logic uv_sum;
		logic gen_err;
	} state_type;

	state_type state_r;
	state_type state_nxt;

	// circular quadrant distance, 0..2
	function automatic logic [2:0] quad_dist(input logic [1:0] a, input logic [1:0] b);
		logic [1:0] d;
		d = a - b;
		quad_dist = (d == 2'h3) ? 3'h1 : {1'b0, d};
	endfunction

	// encoder states arrive gray coded; distance is only meaningful in binary
	function automatic logic [1:0] gray_to_bin(input logic [1:0] g);
		gray_to_bin = {g[1], g[1] ^ g[0]};
	endfunction

	logic [FAULT_W-1:0] fault_ev;
	logic [CAUTION_W-1:0] caution_ev;
	logic enc_skip;
	logic [11:0] jump;
	logic [2:0] span_now;

	// ****************************************
	// event detection
	// ****************************************
	always_comb begin
		fault_ev = '0;
		caution_ev = '0;
		// two-state jump in gray sequence means a state was missed
		enc_skip = state_r.enc_valid
			&& (quad_dist(gray_to_bin(mon.enc_state), gray_to_bin(state_r.enc_prev)) == 3'h2);
		jump = mon.angle - state_r.turn_angle;
		if (jump[11]) begin
			jump = 12'h000 - jump;
		end
		span_now = quad_dist(mon.angle[11:10], state_r.quad_first);
		fault_ev[`FLT_SUPPLY_LOW] = mon.supply_low;
		fault_ev[`FLT_FIELD_LOW] = (field_low_limit != `FIELD_THR_OFF)
			&& (field_level_lo < field_low_limit);
		fault_ev[`FLT_OSC] = mon.osc_mismatch;
		fault_ev[`FLT_NVM_UNCORR] = mon.nvm_multi;
		fault_ev[`FLT_ZERO_CROSS] = mon.zero_cross_diff;
		fault_ev[`FLT_PLL] = mon.pll_unlocked;
		fault_ev[`FLT_ENC_SKIP] = mon.enc_step && enc_skip;
		fault_ev[`FLT_REG_DRIFT] = mon.reg_drift;
		fault_ev[`FLT_AVG_SPAN] = mon.avg_end
			&& (state_r.quad_span >= `QUAD_SPAN_LIMIT);
		caution_ev[`CAU_FIELD_HIGH] = (field_high_limit != `FIELD_THR_OFF)
			&& (field_level_hi > field_high_limit);
		caution_ev[`CAU_TEMP] = mon.temp_out;
		caution_ev[`CAU_NVM_CORR] = mon.nvm_single && !mon.nvm_multi;
		caution_ev[`CAU_TURNS_SAT] = mon.turn_step && mon.turn_up
			&& (state_r.turns == `TURNS_LIMIT);
		caution_ev[`CAU_TURNS_SPEED] = mon.turn_step
			&& (jump > `ANGLE_JUMP_LIMIT);
		caution_ev[`CAU_FRAME] = mon.frame_end && mon.frame_bad;
		caution_ev[`CAU_CRC] = mon.frame_end && mon.frame_is_20bit
			&& crc_check_enable && mon.frame_crc_bad;
	end

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		state_nxt = state_r;
		// set wins over a clear in the same cycle
		state_nxt.fault = (state_r.fault & ~fault_clear) | fault_ev;
		state_nxt.caution = (state_r.caution & ~caution_clear) | caution_ev;
		if (mon.enc_step) begin
			state_nxt.enc_prev = mon.enc_state;
			state_nxt.enc_valid = 1'b1;
		end
		if (mon.turn_step) begin
			state_nxt.turn_angle = mon.angle;
			// counter holds at limit rather than wrapping
			if (mon.turn_up && state_r.turns != `TURNS_LIMIT) begin
				state_nxt.turns = state_r.turns + 9'h001;
			end else if (!mon.turn_up && state_r.turns != 9'h000) begin
				state_nxt.turns = state_r.turns - 9'h001;
			end
		end
		if (mon.avg_end || !state_r.span_valid) begin
			state_nxt.quad_first = mon.angle[11:10];
			state_nxt.quad_span = 3'h0;
			state_nxt.span_valid = 1'b1;
		end else if (span_now > state_r.quad_span) begin
			state_nxt.quad_span = span_now;
		end
		state_nxt.uv_sum = state_nxt.fault[`FLT_SUPPLY_LOW]
			| state_nxt.fault[`FLT_REG_DRIFT];
		state_nxt.gen_err = |(state_nxt.fault & ~fault_mask)
			| |(state_nxt.caution & ~caution_mask);
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= '0;
			// reset means power was lost, so the flag starts set
			state_r.fault[`FLT_POWER_LOSS] <= 1'b1;
			state_r.gen_err <= 1'b1;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	always_comb begin
		flags.fault_word = state_r.fault;
		flags.caution_word = state_r.caution;
		flags.undervoltage_summary = state_r.uv_sum;
		flags.general_error_flag = state_r.gen_err;
	end

endmodule
`default_nettype wire

// File: fault_flag_aggregator_asserts.sv
// assertion checker for the flag aggregator
`timescale 1ns/1ps
`default_nettype none
module fault_flag_aggregator_asserts
	import fault_flags_pkg::*;
#(parameter int FAULT_W = 10, parameter int CAUTION_W = 7) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire fault_flags_pkg::monitor_in_type mon,
	input wire logic [5:0] field_level_hi,
	input wire logic [5:0] field_level_lo,
	input wire logic [5:0] field_high_limit,
	input wire logic [5:0] field_low_limit,
	input wire logic crc_check_enable,
	input wire logic [FAULT_W-1:0] fault_mask,
	input wire logic [CAUTION_W-1:0] caution_mask,
	input wire logic [FAULT_W-1:0] fault_clear,
	input wire logic [CAUTION_W-1:0] caution_clear,
	input wire fault_flags_pkg::flag_out_type flags
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	sequence s_held;
		flags.fault_word[5] && !fault_clear[5];
	endsequence
	sequence s_wipe;
		fault_clear[5] && !mon.pll_unlocked;
	endsequence
	property p_sup;
		mon.supply_low |=> flags.fault_word[0] && flags.undervoltage_summary;
	endproperty
	property p_fhi;
		field_high_limit != 6'h00 && field_level_hi > field_high_limit |=> flags.caution_word[0];
	endproperty
	property p_flo;
		field_low_limit != 6'h00 && field_level_lo < field_low_limit |=> flags.fault_word[1];
	endproperty
	property p_tmp;
		mon.temp_out |=> flags.caution_word[1];
	endproperty
	property p_unc;
		mon.nvm_multi |=> flags.fault_word[3] && (fault_mask[3] || flags.general_error_flag);
	endproperty
	property p_drf;
		mon.reg_drift |=> flags.fault_word[8] && flags.undervoltage_summary;
	endproperty
	property p_crc;
		mon.frame_end && mon.frame_crc_bad && mon.frame_is_20bit && crc_check_enable
			|=> flags.caution_word[6];
	endproperty
	property p_hold;
		s_held |=> flags.fault_word[5];
	endproperty
	property p_wipe;
		s_wipe |=> !flags.fault_word[5];
	endproperty
	a_sup: assert property (p_sup) else $error("supply low not flagged");
	a_fhi: assert property (p_fhi) else $error("field high missed");
	a_flo: assert property (p_flo) else $error("field low missed");
	a_tmp: assert property (p_tmp) else $error("temp flag missed");
	a_unc: assert property (p_unc) else $error("nvm multi missed");
	a_drf: assert property (p_drf) else $error("drift missed");
	a_crc: assert property (p_crc) else $error("crc flag missed");
	a_hold: assert property (p_hold) else $error("flag lost");
	a_wipe: assert property (p_wipe) else $error("clear ignored");
endmodule
bind fault_flag_aggregator fault_flag_aggregator_asserts #(.FAULT_W(FAULT_W),
	.CAUTION_W(CAUTION_W)) u_chk (.clk_sys(clk_sys), .rst_b(rst_b), .mon(mon),
	.field_level_hi(field_level_hi), .field_level_lo(field_level_lo),
	.field_high_limit(field_high_limit), .field_low_limit(field_low_limit),
	.crc_check_enable(crc_check_enable), .fault_mask(fault_mask),
	.caution_mask(caution_mask), .fault_clear(fault_clear),
	.caution_clear(caution_clear), .flags(flags));
`default_nettype wire

// File: flag_host.sv
// host model that reads the flags and clears them
`timescale 1ns/1ps
`default_nettype none
module flag_host
	import fault_flags_pkg::*;
(
	// host side
	input wire logic rd,
	input wire fault_flags_pkg::flag_out_type flags,
	output logic [9:0] fault_clear,
	output logic [6:0] caution_clear
);
	// clears only what it read, so a later event is never lost
	assign fault_clear = rd ? flags.fault_word : 10'h000;
	assign caution_clear = rd ? flags.caution_word : 7'h00;
endmodule
`default_nettype wire

// File: fault_flag_aggregator_tb_top.sv
// testbench for the flag aggregator
`timescale 1ns/1ps
`default_nettype none
module fault_flag_aggregator_tb_top;
	import fault_flags_pkg::*;
	logic clk_sys = 0, rst_b = 0, rd = 0, crc_en = 0;
	monitor_in_type mon = '0, m;
	logic [5:0] lv_hi = 0, lv_lo = 6'h3f, lim_hi = 6'h25, lim_lo = 6'h0d;
	logic [9:0] fm = 0, fclr;
	logic [6:0] cm = 0, cclr;
	logic [9:0] fx[8] = '{10'h001, 10'h004, 10'h008, 10'h010, 10'h020, 10'h100, 0, 0};
	logic [6:0] cx[8] = '{0, 0, 0, 0, 0, 0, 7'h02, 7'h04};
	logic [1:0] gs[5] = '{2'b01, 2'b11, 2'b10, 2'b00, 2'b11};
	flag_out_type flags, e;
	flag_out_type q[$];
	int n_mismatch = 0, check_count = 0;
	always #2.5 clk_sys = ~clk_sys;
	fault_flag_aggregator DUT (.clk_sys(clk_sys), .rst_b(rst_b), .mon(mon),
		.field_level_hi(lv_hi), .field_level_lo(lv_lo), .field_high_limit(lim_hi),
		.field_low_limit(lim_lo), .crc_check_enable(crc_en), .fault_mask(fm),
		.caution_mask(cm), .fault_clear(fclr), .caution_clear(cclr), .flags(flags));
	flag_host host (.rd(rd), .flags(flags), .fault_clear(fclr), .caution_clear(cclr));
	// note the outcome one edge after the inputs land
	task ap(input monitor_in_type mm, input logic [9:0] ef, input logic [6:0] ec);
		mon = mm;
		@(posedge clk_sys);
		q.push_back({ef, ec, ef[0] | ef[8], |(ef & ~fm) | |(ec & ~cm)});
		#1;
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	always @(negedge clk_sys) if (q.size() > 0) begin
		e = q.pop_front();
		check_count++;
		if (flags !== e) begin
			n_mismatch++;
			$display("BAD %0t flags %h want %h", $time, flags, e);
		end
	end
	initial begin
		#5000;
		n_mismatch++;
		give_verdict;
	end
	initial begin
		void'($urandom(32'h013a));
		repeat (6) @(posedge clk_sys);
		#1;
		rst_b = 1;
		ap('0, 10'h040, 0);
		rd = 1;
		ap('0, 0, 0);
		rd = 0;
		$display("reset test done");
		for (int i = 0; i < 8; i++) begin
			m = '0;
			case (i)
				0: m.supply_low = 1;
				1: m.osc_mismatch = 1;
				2: m.nvm_multi = 1;
				3: m.zero_cross_diff = 1;
				4: m.pll_unlocked = 1;
				5: m.reg_drift = 1;
				6: m.temp_out = 1;
				default: m.nvm_single = 1;
			endcase
			// random levels stay inside the default window
			lv_hi = 6'($urandom_range(37));
			lv_lo = 6'($urandom_range(63, 13));
			ap(m, fx[i], cx[i]);
			ap('0, fx[i], cx[i]);
			rd = 1;
			ap('0, 0, 0);
			rd = 0;
		end
		$display("condition test done");
		lim_hi = 6'h05;
		lim_lo = 6'h05;
		lv_hi = 6'h05;
		lv_lo = 6'h05;
		ap('0, 0, 0);
		lv_hi = 6'h06;
		lv_lo = 6'h04;
		ap('0, 10'h002, 7'h01);
		rd = 1;
		lim_hi = 0;
		lim_lo = 0;
		ap('0, 0, 0);
		rd = 0;
		$display("field test done");
		m = '0;
		m.frame_end = 1;
		m.frame_crc_bad = 1;
		m.frame_is_20bit = 1;
		ap(m, 0, 0);
		crc_en = 1;
		m.frame_bad = 1;
		ap(m, 0, 7'h60);
		rd = 1;
		ap('0, 0, 0);
		rd = 0;
		// gray walk with a wrap, then a two-step jump
		m = '0;
		m.enc_step = 1;
		for (int k = 0; k < 5; k++) begin
			m.enc_state = gs[k];
			ap(m, (k == 4) ? 10'h080 : 10'h000, 0);
		end
		rd = 1;
		ap('0, 0, 0);
		rd = 0;
		m = '0;
		m.turn_step = 1;
		m.turn_up = 1;
		m.angle = 12'h600;
		ap(m, 0, 0);
		m.angle = 12'hc01;
		ap(m, 0, 7'h10);
		rd = 1;
		ap('0, 0, 0);
		rd = 0;
		// count now 2; 254 more up steps reach the limit
		repeat (254) ap(m, 0, 0);
		ap(m, 0, 7'h08);
		rd = 1;
		ap('0, 0, 0);
		rd = 0;
		m = '0;
		m.avg_end = 1;
		ap(m, 0, 0);
		m.avg_end = 0;
		m.angle = 12'h800;
		ap(m, 0, 0);
		m.avg_end = 1;
		m.angle = 12'h000;
		ap(m, 10'h200, 0);
		rd = 1;
		ap('0, 0, 0);
		rd = 0;
		$display("sequence test done");
		fm = '1;
		cm = '1;
		m = '0;
		m.pll_unlocked = 1;
		ap(m, 10'h020, 0);
		$display("frame and mask test done");
		repeat (2) @(posedge clk_sys);
		give_verdict;
	end
endmodule
`default_nettype wire
